//--- design/dpr_pkg.sv
// constants for the ddr2 precharge, refresh and power-down state block
// assumes a 50 MHz ref_clk that samples the command pins on each rising edge
package dpr_pkg;

  localparam int CLK_PERIOD_PS = 20000;

  // command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_NOP   = 4'h7;

  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BANKS  = 8'h08;
  localparam logic [7:0] REG_REFCNT = 8'h0c;

  // ctrl field positions and reset value
  localparam int CTRL_FAST_EXIT_BIT = 0;
  localparam int CTRL_DLL_EN_BIT    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // self refresh internal refresh interval, 7.8 us
  localparam int TREFI_NS     = 7800;
  localparam int TREFI_CYCLES = (TREFI_NS * 1000) / CLK_PERIOD_PS;

  // internal operation busy time after precharge, activate or refresh
  localparam int TBUSY_NS     = 60;
  localparam int TBUSY_CYCLES = (TBUSY_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    DPR_ACTIVE  = 4'h1,
    DPR_SELFREF = 4'h2,
    DPR_PPD     = 4'h4,
    DPR_APD     = 4'h8
  } dpr_state_type;

endpackage : dpr_pkg

//--- design/dpr_core.sv
// device side command state tracker: banks, self refresh and power-down
// assumes ddr2 command pins arrive from another clock domain (synchronised)
// Operation
// - refresh with cke low and banks idle enters self refresh
// - self refresh disables all buffers except cke
// - cke low with nop or deselect enters power-down
// - running internal operations finish before power-down state is reached
// - idle banks give precharge power-down, open row gives active
// - dll off in precharge and slow-exit active power-down
// - cke high with nop or deselect exits power-down
// - command decode from cs, ras, cas, we; a10 selects ap or all
// - bank address picks one of eight banks; a10 high on precharge means all
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dpr_core #(
  parameter int NUM_BANKS    = 8,
  parameter int TREFI_CYCLES = dpr_pkg::TREFI_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        a10,
  input  wire logic [2:0]  ba,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             io_buf_en,
  output logic             dll_en,
  output logic             self_refresh,
  output logic             power_down,
  output logic             internal_refresh
);

  // two-stage synchronisers; stage one read only by stage two
  logic [9:0] pin_s1_q;
  logic [9:0] pin_s2_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // idle pins: cke high and deselect, so no false cke edge follows reset
      pin_s1_q <= 10'h3fe;
      pin_s2_q <= 10'h3fe;
    end else begin
      pin_s1_q <= {cke, cs_n, ras_n, cas_n, we_n, a10, ba, 1'b0};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic       cke_s;
  logic       a10_s;
  logic [2:0] ba_s;
  logic [3:0] cmd;
  assign cke_s = pin_s2_q[9];
  assign a10_s = pin_s2_q[4];
  assign ba_s  = pin_s2_q[3:1];
  assign cmd   = pin_s2_q[8:5];

  logic cke_prev_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      cke_prev_q <= 1'b1;
    else
      cke_prev_q <= cke_s;
  end

  // deselect ignores ras/cas/we
  function automatic logic is_nop(input logic [3:0] c);
    is_nop = c[3] || (c == dpr_pkg::CMD_NOP);
  endfunction

  function automatic logic is_cmd(input logic [3:0] c,
                                  input logic [3:0] code);
    is_cmd = !c[3] && (c == code);
  endfunction

  logic both_high;
  assign both_high = cke_prev_q && cke_s;

  // bank open tracking and precharge period
  logic [NUM_BANKS-1:0] bank_open_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bank_open_q <= '0;
    end else if (both_high) begin
      if (is_cmd(cmd, dpr_pkg::CMD_ACT))
        bank_open_q[ba_s] <= 1'b1;
      else if (is_cmd(cmd, dpr_pkg::CMD_PRE)) begin
        if (a10_s)
          bank_open_q <= '0;
        else
          bank_open_q[ba_s] <= 1'b0;
      end else if (is_cmd(cmd, dpr_pkg::CMD_READ) ||
                   is_cmd(cmd, dpr_pkg::CMD_WRITE)) begin
        if (a10_s)
          bank_open_q[ba_s] <= 1'b0;
      end
    end
  end

  // internal operation busy counter; refreshed by act/pre/ref
  logic [7:0] busy_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      busy_q <= 8'h00;
    else if (both_high && (is_cmd(cmd, dpr_pkg::CMD_ACT) ||
                           is_cmd(cmd, dpr_pkg::CMD_PRE) ||
                           is_cmd(cmd, dpr_pkg::CMD_REF)))
      busy_q <= 8'(dpr_pkg::TBUSY_CYCLES);
    else if (busy_q != 8'h00)
      busy_q <= busy_q - 8'h01;
  end

  // registers
  logic [1:0] ctrl_q;
  logic       wb_hit;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      ctrl_q <= dpr_pkg::CTRL_RESET;
    else if (wb_hit && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == dpr_pkg::REG_CTRL)
      ctrl_q <= wb_dat_i[1:0];
  end

  // main state machine
  dpr_pkg::dpr_state_type state_q;
  dpr_pkg::dpr_state_type state_d;
  logic          pd_pending_q;
  logic          pd_pending_d;
  always_comb begin
    state_d      = state_q;
    pd_pending_d = pd_pending_q;
    case (state_q)
      dpr_pkg::DPR_ACTIVE: begin
        if (cke_prev_q && !cke_s) begin
          if (is_cmd(cmd, dpr_pkg::CMD_REF) && bank_open_q == '0)
            state_d = dpr_pkg::DPR_SELFREF;
          else if (is_nop(cmd))
            pd_pending_d = 1'b1;
        end
        if (pd_pending_q && !cke_s && busy_q == 8'h00) begin
          pd_pending_d = 1'b0;
          state_d = (bank_open_q == '0) ? dpr_pkg::DPR_PPD
                                        : dpr_pkg::DPR_APD;
        end else if (pd_pending_q && cke_s && is_nop(cmd))
          pd_pending_d = 1'b0;
      end
      dpr_pkg::DPR_SELFREF: begin
        if (cke_s && is_nop(cmd))
          state_d = dpr_pkg::DPR_ACTIVE;
      end
      dpr_pkg::DPR_PPD,
      dpr_pkg::DPR_APD: begin
        if (cke_s && is_nop(cmd))
          state_d = dpr_pkg::DPR_ACTIVE;
      end
      default: begin
        state_d      = dpr_pkg::DPR_ACTIVE;
        pd_pending_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q      <= dpr_pkg::DPR_ACTIVE;
      pd_pending_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      pd_pending_q <= pd_pending_d;
    end
  end

  // self refresh keeps rows alive on its own timer
  logic [19:0] sr_tmr_q;
  logic [15:0] ref_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sr_tmr_q  <= 20'h00000;
      ref_cnt_q <= 16'h0000;
    end else if (state_q != dpr_pkg::DPR_SELFREF) begin
      sr_tmr_q <= 20'h00000;
    end else if (sr_tmr_q == 20'(TREFI_CYCLES - 1)) begin
      sr_tmr_q  <= 20'h00000;
      ref_cnt_q <= ref_cnt_q + 16'h0001;
    end else begin
      sr_tmr_q <= sr_tmr_q + 20'h00001;
    end
  end

  // outputs from flip-flops
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      io_buf_en        <= 1'b1;
      dll_en           <= 1'b1;
      self_refresh     <= 1'b0;
      power_down       <= 1'b0;
      internal_refresh <= 1'b0;
    end else begin
      io_buf_en    <= (state_d == dpr_pkg::DPR_ACTIVE);
      self_refresh <= (state_d == dpr_pkg::DPR_SELFREF);
      power_down   <= (state_d == dpr_pkg::DPR_PPD) ||
                      (state_d == dpr_pkg::DPR_APD);
      internal_refresh <= (state_q == dpr_pkg::DPR_SELFREF) &&
                          (sr_tmr_q == 20'(TREFI_CYCLES - 1));
      case (state_d)
        dpr_pkg::DPR_PPD,
        dpr_pkg::DPR_SELFREF: dll_en <= 1'b0;
        dpr_pkg::DPR_APD: dll_en <= ctrl_q[dpr_pkg::CTRL_FAST_EXIT_BIT] &&
                                   ctrl_q[dpr_pkg::CTRL_DLL_EN_BIT];
        default: dll_en <= ctrl_q[dpr_pkg::CTRL_DLL_EN_BIT];
      endcase
    end
  end

  // wishbone slave, registered ack one cycle after the strobe (one wait state); unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          dpr_pkg::REG_CTRL:   wb_dat_o <= {30'h0, ctrl_q};
          dpr_pkg::REG_STATUS: wb_dat_o <= {26'h0, pd_pending_q,
                                            busy_q != 8'h00, state_q};
          dpr_pkg::REG_BANKS:  wb_dat_o <= 32'(bank_open_q);
          dpr_pkg::REG_REFCNT: wb_dat_o <= {16'h0, ref_cnt_q};
          default:             wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // dpr_core

`default_nettype wire

//--- sim/dpr_core_props.sv
// checker on dpr_core low-power outputs and the pins behind them
// assumes reset is held long enough to flush the pin syncs
`timescale 1ns/1ps
`default_nettype none
module dpr_core_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic io_buf_en,
  input wire logic dll_en,
  input wire logic self_refresh,
  input wire logic power_down,
  input wire logic internal_refresh
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // the state lags the pins by about four edges, so windows are wide
  sequence s_wake; (cke && cs_n) [*6]; endsequence
  sequence s_sleep; (!cke && cs_n) [*8]; endsequence
  a_sr_quiet: assert property (self_refresh |-> !io_buf_en && !dll_en)
    else $error("self refresh with buffers or dll on");
  a_pd_quiet: assert property (power_down |-> !io_buf_en)
    else $error("power-down with buffers on");
  a_mode_excl: assert property (!(self_refresh && power_down))
    else $error("two low-power modes at once");
  a_sr_hold: assert property ((self_refresh && !cke) [*6] |=> self_refresh)
    else $error("self refresh left with cke low");
  a_pd_enter: assert property (s_sleep |-> power_down || self_refresh)
    else $error("no power-down after cke low");
  a_pd_wake: assert property (s_wake |-> !power_down && !self_refresh)
    else $error("no exit after cke high");
  a_ref_gap: assert property (internal_refresh |=> !internal_refresh [*7])
    else $error("internal refresh too often");
  a_ref_in_sr: assert property (internal_refresh |->
    self_refresh || $past(self_refresh))
    else $error("internal refresh outside self refresh");
endmodule // dpr_core_props
bind dpr_core dpr_core_props u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
  .io_buf_en(io_buf_en), .dll_en(dll_en), .self_refresh(self_refresh),
  .power_down(power_down), .internal_refresh(internal_refresh));
`default_nettype wire

//--- sim/dpr_ctl_model.sv
// controller model driving the ddr2 command pins and cke
// assumes cmd() is called from one bench process only
`timescale 1ns/1ps
`default_nettype none
module dpr_ctl_model (
  input  wire logic       ref_clk,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic            a10,
  output logic [2:0]      ba
);
  // controller timing in clocks; plain defaults, the device checks none
  localparam int TCK_PS  = 20000;
  localparam int TRTP_PS = 7500;
  localparam int RTP     = (TRTP_PS + TCK_PS - 1) / TCK_PS;
  localparam int AL      = 0;
  localparam int BL      = 4;
  localparam int WL      = 2;
  localparam int TWR_CK  = 1;
  localparam int WR      = 3;
  localparam int TRP_CK  = 1;
  localparam int TMRD_CK = 2;
  localparam int RD_PRE  = AL + BL / 2 + ((RTP > 2) ? RTP : 2) - 2;
  localparam int WR_PRE  = WL + BL / 2 + TWR_CK;
  localparam int WRA_PRE = WL + BL / 2 + WR;
  localparam int PRE_ALL = TRP_CK + 1;
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, a10, ba} = 9'h1ff;
  end
  // one command edge, then deselect with the don't-care lines scrambled
  task automatic cmd(input logic [3:0] c, input logic ap,
                     input logic [2:0] b, input logic ck);
    logic chg;
    chg = (ck !== cke);
    @(posedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    a10 <= ap;
    ba <= b;
    cke <= ck;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~c[2:0];
    a10 <= ~ap;
    ba <= ~b;
    if (chg) repeat (2) @(posedge ref_clk);
    // worst-case spacing after read, write, precharge and mrs, whatever follows it; none after others
    case (c)
      dpr_pkg::CMD_READ:  repeat (RD_PRE) @(posedge ref_clk);
      dpr_pkg::CMD_WRITE:
        repeat (ap ? WRA_PRE : WR_PRE) @(posedge ref_clk);
      dpr_pkg::CMD_PRE:   repeat (PRE_ALL) @(posedge ref_clk);
      dpr_pkg::CMD_MRS:   repeat (TMRD_CK) @(posedge ref_clk);
      default: ;
    endcase
  endtask
endmodule // dpr_ctl_model
`default_nettype wire

//--- sim/tb_dpr_core.sv
// bench for dpr_core: pin commands via the model, registers via wishbone
// assumes dpr_ctl_model owns the pins and this module owns the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dpr_core;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cke, cs_n, ras_n, cas_n, we_n, a10;
  logic [2:0]  ba;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q, r1;
  logic        ack, io_buf_en, dll_en, sr, pd, irf;
  int          mismatches = 0;
  int          checks_done = 0;
  int          pulses = 0;
  int          half_ns = 10;
  initial forever #(half_ns) ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (irf === 1'b1) pulses <= pulses + 1;
  dpr_ctl_model u_ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba));
  dpr_core #(.TREFI_CYCLES(8)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .a10(a10), .ba(ba), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .io_buf_en(io_buf_en), .dll_en(dll_en),
    .self_refresh(sr), .power_down(pd), .internal_refresh(irf));
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ack is read at the edge itself, before that edge's updates land
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hf};
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic settle(input logic [1:0] want);
    int n;
    n = 0;
    while ({pd, sr} !== want && n < 30) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK({pd, sr}, want)
    if ({pd, sr} !== want) summarize();
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    wb(1'b0, dpr_pkg::REG_CTRL, 32'h0);
    `CHK(q, 32'h2)
    wb(1'b0, dpr_pkg::REG_STATUS, 32'h0);
    `CHK(q, 32'h1)
    wb(1'b0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    u_ctl.cmd(dpr_pkg::CMD_ACT, 1'b0, 3'h3, 1'b1);
    u_ctl.cmd(dpr_pkg::CMD_ACT, 1'b0, 3'h5, 1'b1);
    u_ctl.cmd(dpr_pkg::CMD_PRE, 1'b0, 3'h3, 1'b1);
    u_ctl.cmd(dpr_pkg::CMD_READ, 1'b0, 3'h5, 1'b1);
    repeat (4) @(posedge ref_clk);
    wb(1'b0, dpr_pkg::REG_BANKS, 32'h0);
    `CHK(q[7:0], 8'h20)
    u_ctl.cmd(dpr_pkg::CMD_PRE, 1'b1, 3'h0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      u_ctl.cmd(dpr_pkg::CMD_ACT, 1'b0, 3'h6, 1'b1);
      u_ctl.cmd(i ? dpr_pkg::CMD_WRITE : dpr_pkg::CMD_READ,
                1'b1, 3'h6, 1'b1);
      repeat (4) @(posedge ref_clk);
      wb(1'b0, dpr_pkg::REG_BANKS, 32'h0);
      `CHK(q[7:0], 8'h00)
    end
    u_ctl.cmd(dpr_pkg::CMD_MRS, 1'b0, 3'h0, 1'b1);
    settle(2'b00);
    for (int f = 0; f < 2; f++) begin
      wb(1'b1, dpr_pkg::REG_CTRL, {30'h0, 1'b1, f[0]});
      u_ctl.cmd(dpr_pkg::CMD_ACT, 1'b0, 3'h1, 1'b1);
      u_ctl.cmd(dpr_pkg::CMD_NOP, 1'b0, 3'h0, 1'b0);
      settle(2'b10);
      wb(1'b0, dpr_pkg::REG_STATUS, 32'h0);
      `CHK({q[3:0], io_buf_en, dll_en}, {4'h8, 1'b0, f[0]})
      u_ctl.cmd(dpr_pkg::CMD_NOP, 1'b0, 3'h0, 1'b1);
      settle(2'b00);
      u_ctl.cmd(dpr_pkg::CMD_PRE, 1'b1, 3'h0, 1'b1);
    end
    u_ctl.cmd(4'hf, 1'b0, 3'h0, 1'b0);
    settle(2'b10);
    // clock may only move in precharge power-down, cke long since low
    half_ns = 12;
    repeat (6) @(posedge ref_clk);
    half_ns = 10;
    repeat (6) @(posedge ref_clk);
    wb(1'b0, dpr_pkg::REG_STATUS, 32'h0);
    `CHK({q[3:0], dll_en}, {4'h4, 1'b0})
    u_ctl.cmd(4'hf, 1'b0, 3'h0, 1'b1);
    settle(2'b00);
    u_ctl.cmd(dpr_pkg::CMD_MRS, 1'b0, 3'h0, 1'b1);
    u_ctl.cmd(dpr_pkg::CMD_REF, 1'b0, 3'h0, 1'b1);
    repeat (8) @(posedge ref_clk);
    `CHK(sr, 1'b0)
    u_ctl.cmd(dpr_pkg::CMD_REF, 1'b0, 3'h0, 1'b0);
    settle(2'b01);
    `CHK({io_buf_en, dll_en}, 2'b00)
    wb(1'b0, dpr_pkg::REG_REFCNT, 32'h0);
    r1 = q;
    repeat (32) @(posedge ref_clk);
    wb(1'b0, dpr_pkg::REG_REFCNT, 32'h0);
    r1 = q - r1;
    `CHK(r1[15:2], 14'h1)
    u_ctl.cmd(dpr_pkg::CMD_NOP, 1'b0, 3'h0, 1'b1);
    settle(2'b00);
    `CHK(io_buf_en, 1'b1)
    wb(1'b0, dpr_pkg::REG_REFCNT, 32'h0);
    `CHK(q[15:0], 16'(pulses))
    // only deselect while the array recovers from self refresh
    repeat (40) @(posedge ref_clk);
    u_ctl.cmd(dpr_pkg::CMD_REF, 1'b0, 3'h0, 1'b1);
    repeat (4) @(posedge ref_clk);
    `CHK({pd, sr}, 2'b00)
    summarize();
  end
endmodule // tb_dpr_core
`default_nettype wire
